// ===== lsc_shutdown_ctrl.sv
// shutdown control: software release bit, hardware pin, serial reset pulse
`timescale 1ns/1ns
`default_nettype none

// Contract
// - registers keep contents during any shutdown
// - release bit zero means software shutdown
// - software shutdown darkens outputs, registers stay accessible
// - release bit powers up zero; host sets it
// - pin low forces hardware shutdown
// - pin high ends hardware shutdown
// - pin rising edge resets serial interface only
// - register access continues while pin low
// - key write or power-up restores defaults
module lsc_shutdown_ctrl
   import lsc_pkg::*;
(
   input  wire logic      REF_CLK_IN,      // 250 mhz device clock
   input  wire logic      RESET_N_IN,      // power-on reset, active low
   input  wire logic      SHUTDOWN_PIN_N_IN, // asynchronous shutdown pin, active low
   input  wire lsc_wr_t   REG_WR_IN,       // register write from serial interface
   output logic           SHUTDOWN_RELEASE_BIT_OUT, // stored release bit
   output lsc_stat_t      STATUS_OUT,      // shutdown status, from flip-flops
   output logic           OUT_ENABLE_OUT,  // gate for all current sources
   output logic           SERIAL_RESET_OUT, // one-cycle reset to serial logic
   output logic           REG_DEFAULT_OUT  // one-cycle restore-defaults strobe
);

   // synchroniser, edge detector and stored state
   logic pin_meta_r;                       // first synchroniser stage
   logic pin_sync_r;                       // second stage, safe to read
   logic pin_prev_r;                       // last sampled level, edge detect
   logic release_r;                        // shutdown release bit
   logic out_en_r;                         // registered output enable
   logic ser_rst_r;                        // serial reset pulse
   logic dflt_r;                           // restore-defaults pulse
   logic release_nxt;                      // next release bit
   logic key_write;                        // reset key seen this cycle
   lsc_stat_t stat_r;                      // registered status

   // write decoder shared by both register hits
   function automatic logic hit(input lsc_wr_t w, input logic [7:0] a);
      hit = w.valid && (w.addr == a);
   endfunction : hit

   // two-flop synchroniser on the pin; only stage two is read
   // limitation: pin pulses shorter than a clock may be missed
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      // preset high so reset release looks like an idle pin
      if (!RESET_N_IN) begin
         pin_meta_r <= PIN_SYNC_INIT;
         pin_sync_r <= PIN_SYNC_INIT;
      // stage one may go metastable; stage two gives it a cycle
      end else begin
         pin_meta_r <= SHUTDOWN_PIN_N_IN;
         pin_sync_r <= pin_meta_r;
      end
   end

   // edge history for the rising-edge detector
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      // same preset as the synchroniser: no false edge after reset
      if (!RESET_N_IN) begin
         pin_prev_r <= PIN_SYNC_INIT;
      // one-cycle delayed copy of the synchronised pin
      end else begin
         pin_prev_r <= pin_sync_r;
      end
   end

   // a wrong key is ignored, so stray writes cannot wipe the setup
   // key write to reset register
   assign key_write = hit(REG_WR_IN, RESET_ADDR) && (REG_WR_IN.data == RESET_KEY);

   // release bit next value; writes are never blocked by shutdown
   always_comb begin
      // default: keep the stored bit
      release_nxt = release_r;
      if (key_write) begin
         release_nxt = REL_DEFAULT;
      // access stays open in any shutdown
      end else if (hit(REG_WR_IN, CTRL_ADDR)) begin
         release_nxt = REG_WR_IN.data[REL_BIT];
      end
   end

   // release bit storage; shutdown itself never touches it
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         release_r <= REL_DEFAULT;
      // held through shutdown and pin edges
      end else begin
         release_r <= release_nxt;
      end
   end

   // output gate, status and pulses
   // registered so the gate cannot glitch while the bit is rewritten
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      // power-up: dark outputs, no pulses
      if (!RESET_N_IN) begin
         out_en_r  <= 1'b0;
         stat_r    <= '0;
         ser_rst_r <= 1'b0;
         dflt_r    <= 1'b0;
      // running: levels follow the sampled inputs
      end else begin
         out_en_r           <= release_r && pin_sync_r;
         // software shutdown when bit is zero
         stat_r.sw_shutdown <= !release_r;
         stat_r.hw_shutdown <= !pin_sync_r;
         stat_r.outputs_on  <= release_r && pin_sync_r;
         ser_rst_r          <= pin_sync_r && !pin_prev_r;
         // strobe the rest of the register file
         dflt_r             <= key_write;
      end
   end

   // every output is a flip-flop or a plain wire to one
   assign SHUTDOWN_RELEASE_BIT_OUT = release_r;
   assign STATUS_OUT               = stat_r;
   assign OUT_ENABLE_OUT           = out_en_r;
   assign SERIAL_RESET_OUT         = ser_rst_r;
   assign REG_DEFAULT_OUT          = dflt_r;

   // outputs dark whenever released bit is clear
   sw_dark_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      !release_r |=> !out_en_r)
      else $error("outputs on during software shutdown");

   // outputs dark while pin low
   hw_dark_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      !pin_sync_r |=> !out_en_r)
      else $error("outputs on during hardware shutdown");

   // run exactly when both allow
   out_gate_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      out_en_r == $past(release_r && pin_sync_r))
      else $error("output gate mismatch");

   // pin release re-enables when released
   hw_exit_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (pin_sync_r && release_r && $stable(release_r)) |=> out_en_r)
      else $error("outputs not restored after pin high");

   // one reset pulse per rising edge
   ser_pulse_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $rose(pin_sync_r) |=> SERIAL_RESET_OUT ##1 !SERIAL_RESET_OUT)
      else $error("serial reset pulse wrong");

   // bit holds unless written
   bit_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      !REG_WR_IN.valid |=> $stable(release_r))
      else $error("release bit changed without write");

   // write takes effect while pin low
   wr_in_hw_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (!pin_sync_r && hit(REG_WR_IN, CTRL_ADDR) && !key_write)
      |=> release_r == $past(REG_WR_IN.data[REL_BIT]))
      else $error("write lost during hardware shutdown");

   // write accepted in software shutdown
   wr_in_sw_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (!release_r && hit(REG_WR_IN, CTRL_ADDR) && !key_write)
      |=> release_r == $past(REG_WR_IN.data[REL_BIT]))
      else $error("write lost during software shutdown");

   // key restores default bit
   key_dflt_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      key_write |=> (release_r == REL_DEFAULT) && REG_DEFAULT_OUT)
      else $error("reset key not honoured");

   // serial reset leaves release bit alone
   edge_keep_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (SERIAL_RESET_OUT && !REG_WR_IN.valid) |=> $stable(release_r))
      else $error("serial reset disturbed register");

   // software shutdown status follows the bit one cycle later
   stat_sw_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $past(RESET_N_IN) |-> STATUS_OUT.sw_shutdown == $past(!release_r))
      else $error("software shutdown status wrong");

   // hardware shutdown status follows the synchronised pin
   stat_hw_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $past(RESET_N_IN) |-> STATUS_OUT.hw_shutdown == $past(!pin_sync_r))
      else $error("hardware shutdown status wrong");

   // run flag and output gate never disagree
   stat_on_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      STATUS_OUT.outputs_on == OUT_ENABLE_OUT)
      else $error("run flag and output gate differ");

   // restore strobe only after a key write
   dflt_only_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $past(RESET_N_IN) |-> REG_DEFAULT_OUT == $past(key_write))
      else $error("restore strobe without key");

   // no serial reset without a pin rising edge
   ser_only_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      !$rose(pin_sync_r) |=> !SERIAL_RESET_OUT)
      else $error("serial reset without pin edge");

   // control write lands while running too
   wr_run_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (pin_sync_r && release_r && hit(REG_WR_IN, CTRL_ADDR) && !key_write)
      |=> release_r == $past(REG_WR_IN.data[REL_BIT]))
      else $error("control write lost while running");

   // stage two copies stage one each clock
   sync_path_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $past(RESET_N_IN) |-> pin_sync_r == $past(pin_meta_r))
      else $error("pin synchroniser skipped a stage");

endmodule : lsc_shutdown_ctrl
`default_nettype wire

// ===== lsc_pkg.sv
// package for the led shutdown control block: constants and carrier types
`default_nettype none
package lsc_pkg;
   // control register address and release bit position
   localparam logic [7:0] CTRL_ADDR      = 8'h00;
   localparam int         REL_BIT        = 0;
   // reset register address and the magic key that restores defaults
   localparam logic [7:0] RESET_ADDR     = 8'h3f;
   localparam logic [7:0] RESET_KEY      = 8'hae;
   // power-up value of the release bit: software shutdown
   localparam logic       REL_DEFAULT    = 1'b0;
   // power-up value of the synchroniser stages (pin idles high)
   localparam logic       PIN_SYNC_INIT  = 1'b1;

   // register write carried from the serial interface
   typedef struct packed {
      logic       valid;                   // one-cycle write strobe
      logic [7:0] addr;                    // register address
      logic [7:0] data;                    // write data
   } lsc_wr_t;

   // shutdown status presented to the rest of the device
   typedef struct packed {
      logic outputs_on;                    // current sources may run
      logic sw_shutdown;                   // release bit is 0
      logic hw_shutdown;                   // pin held low
   } lsc_stat_t;
endpackage : lsc_pkg
`default_nettype wire

// ===== lsc_host_model.sv
// host model: drives the shutdown pin and register writes
`timescale 1ns/1ns
`default_nettype none
module lsc_host_model
   import lsc_pkg::*;
(
   input  wire logic clk_in,    // device clock
   output lsc_wr_t   wr_out,    // register write carrier
   output logic      pin_n_out  // shutdown pin, active low
);
   // idle bus, pin released high
   initial begin
      wr_out    = '0;
      pin_n_out = 1'b1;
   end
   // one write; the bus shows inverted junk once released
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_out <= '{valid: 1'b1, addr: a, data: d};
      @(posedge clk_in);
      wr_out <= '{valid: 1'b0, addr: ~a, data: ~d};
   endtask : write_reg
   task automatic set_pin(input logic lvl);
      @(posedge clk_in);
      pin_n_out <= lvl;
   endtask : set_pin
endmodule : lsc_host_model
`default_nettype wire

// ===== lsc_shutdown_ctrl_bench.sv
// self-checking bench for the shutdown control block
`timescale 1ns/1ns
`default_nettype none
module lsc_shutdown_ctrl_bench;
   import lsc_pkg::*;
   logic      clk, rst_n, pin_n, rel, en, srst, dstb; // clock, reset, dut pins
   lsc_wr_t   wr;                                     // host write
   lsc_stat_t st;                                     // status levels
   int        err_total, check_count, n_ser, n_def, cyc; // tallies
   // 250 mhz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   lsc_host_model u_lsc_host_model (.clk_in(clk), .wr_out(wr), .pin_n_out(pin_n));
   lsc_shutdown_ctrl u_lsc_shutdown_ctrl (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
      .SHUTDOWN_PIN_N_IN(pin_n), .REG_WR_IN(wr), .SHUTDOWN_RELEASE_BIT_OUT(rel),
      .STATUS_OUT(st), .OUT_ENABLE_OUT(en), .SERIAL_RESET_OUT(srst), .REG_DEFAULT_OUT(dstb));
   // pulses last one cycle, so count them rather than sample; hang guard
   always @(posedge clk) begin
      if (srst === 1'b1) n_ser <= n_ser + 1;
      if (dstb === 1'b1) n_def <= n_def + 1;
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total = err_total + 1;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // let sync and output stages land, then compare every level
   task automatic lvl(input logic r);
      logic p;
      repeat (4) @(posedge clk);
      #1;
      p = pin_n;
      chk("levels", {3'h0, r, r & p, r & p, ~r, ~p}, {3'h0, rel, en, st});
   endtask : lvl
   task automatic t_soft;
      lvl(1'b0);
      u_lsc_host_model.write_reg(CTRL_ADDR, 8'h01);
      lvl(1'b1);
      u_lsc_host_model.write_reg(8'h05, 8'h00);
      lvl(1'b1);
      u_lsc_host_model.write_reg(CTRL_ADDR, 8'hfe);
      lvl(1'b0);
      u_lsc_host_model.write_reg(CTRL_ADDR, 8'h01);
      lvl(1'b1);
   endtask : t_soft
   // pin low while writes continue, then release
   task automatic t_hard;
      u_lsc_host_model.set_pin(1'b0);
      lvl(1'b1);
      u_lsc_host_model.write_reg(CTRL_ADDR, 8'h00);
      lvl(1'b0);
      u_lsc_host_model.write_reg(CTRL_ADDR, 8'h01);
      u_lsc_host_model.set_pin(1'b1);
      lvl(1'b1);
      chk("serial_reset", 8'h01, n_ser[7:0]);
   endtask : t_hard
   // wrong key ignored, right key restores defaults once
   task automatic t_key;
      u_lsc_host_model.write_reg(RESET_ADDR, 8'h12);
      lvl(1'b1);
      u_lsc_host_model.write_reg(RESET_ADDR, RESET_KEY);
      lvl(1'b0);
      chk("default_strobe", 8'h01, n_def[7:0]);
      chk("serial_reset", 8'h01, n_ser[7:0]);
   endtask : t_key
   // mid-run reset brings back the power-up default, no serial pulse
   task automatic t_reset;
      u_lsc_host_model.write_reg(CTRL_ADDR, 8'h01);
      lvl(1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      lvl(1'b0);
      chk("serial_reset", 8'h01, n_ser[7:0]);
   endtask : t_reset
   task automatic test_done;
      if (err_total == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   // reset for two cycles, then the scenarios
   initial begin
      rst_n = 1'b0;
      err_total = 0;
      check_count = 0;
      n_ser = 0;
      n_def = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_soft();
      t_hard();
      t_key();
      t_reset();
      test_done();
   end
endmodule : lsc_shutdown_ctrl_bench
`default_nettype wire
